// *** shared/tlb_pkg.sv ***
// Constants, register map and carrier types of the translation lookaside block
package tlb_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int TLB_UNITS = 2;
  localparam int TLB_SETS = 64;
  localparam int TLB_WAYS = 2;
  localparam int TLB_SEGS = 16;

  // ----------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_INVAL = 8'h08;
  localparam logic [7:0] REG_SYNC = 8'h0C;
  localparam logic [7:0] REG_INVALL = 8'h10;
  localparam logic [7:0] REG_SEG_BASE = 8'h40;
  localparam logic [7:0] REG_SEG_MASK = 8'hC0;

  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int CTRL_EN = 0;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam int STAT_SYNC = 0;
  localparam int STAT_ILL = 1;
  localparam int STAT_IWALK = 2;
  localparam int STAT_DWALK = 3;
  localparam int SEG_KS = 30;
  localparam int SEG_KP = 29;
  localparam int ATTR_W = 3;
  localparam int ATTR_I = 2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {EXC_NONE, EXC_PROT, EXC_MISS, EXC_ALIGN, EXC_ILLEGAL} tlb_exc_e;
  typedef enum logic {ST_LOOK, ST_WALK} tlb_st_e;

  typedef struct packed {
    logic req;
    logic [31:0] ea;
    logic wr;
    logic ooo;
    logic rdy;
    logic zero;
    logic sup;
  } tlb_req_s;

  typedef struct packed {
    logic done;
    logic hit;
    logic [19:0] real_frame_number;
    logic [3:0] attr;
  } tlb_rsp_s;

  typedef struct packed {
    logic v;
    logic [23:0] segment_identifier;
    logic [3:0] extended_page_index;
    logic [5:0] abbreviated_page_index;
    logic [19:0] real_frame_number;
    logic [3:0] storage_attributes;
    logic [1:0] pp;
    logic c;
  } tlb_ent_s;

  typedef struct packed {
    logic req;
    logic side;
    logic chg;
    logic [39:0] virtual_page_number;
  } tlb_walk_s;

  typedef struct packed {
    logic done;
    logic found;
    logic [19:0] real_frame_number;
    logic [3:0] storage_attributes;
    logic [1:0] pp;
    logic c;
  } tlb_wret_s;

endpackage

// *** rtl/tlb_top.sv ***
// Instruction and data translation lookaside buffers with segment registers
//
// Our own choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/10ps
// What this block does
// - Two 128-entry buffers: instruction and data
// - Two ways, 64 sets, both read together
// - Segment register writes update both copies
// - Top four address bits pick segment register
// - Address bits 14-19 select the set
// - Hit needs valid and full 40-bit match
// - Entry keeps extended page index bits 10-13
// - Miss starts walk unless out of order
// - Refill into invalid or LRU way, retry
// - One LRU bit per set, any use
// - Protection checked first on hit
// - Clear changed bit on write starts walk
// - Otherwise real frame and attributes go out
// - At most one exception reported at once
// - Miss faults wait for pipeline readiness
// - Reset disables translation, keeps valid bits
// - Invalidate clears both ways in both buffers
// - No invalidation broadcast nor snoop
// - Sync stalls while sync-hold is asserted
// - Invalidate-all raises illegal instruction
// - Zero-block to W or I page faults
module tlb_top (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input tlb_pkg::tlb_req_s I_REQ,
  input tlb_pkg::tlb_req_s D_REQ,
  output tlb_pkg::tlb_rsp_s I_RSP,
  output tlb_pkg::tlb_rsp_s D_RSP,
  output tlb_pkg::tlb_walk_s WALK_REQ,
  input tlb_pkg::tlb_wret_s WALK_RET,
  input wire logic SYNC_HOLD,
  output logic SYNC_STALL,
  output logic EXC_VALID,
  output logic EXC_SIDE,
  output tlb_pkg::tlb_exc_e EXC_CODE
);
  import tlb_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  tlb_ent_s ent [TLB_UNITS][TLB_SETS][TLB_WAYS];
  logic lru [TLB_UNITS][TLB_SETS];
  logic [31:0] seg [TLB_UNITS][TLB_SEGS];
  tlb_st_e st [TLB_UNITS];
  tlb_exc_e fc [TLB_UNITS];
  tlb_rsp_s rsp [TLB_UNITS];
  logic [39:0] vpn_r [TLB_UNITS];
  logic [1:0] chg_r;
  logic [1:0] way_r;
  logic en_r;
  logic ill_pend;
  logic hs1;
  logic hs2;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Register select shared by read mux and write strobes
  function automatic logic at(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic bus_go;
  logic bw;
  logic is_seg;
  logic bus_inv;
  logic [5:0] inv_idx;
  logic [31:0] next_rdata;
  assign bus_go = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  assign bw = AVS_WRITE && !AVS_WAITREQUEST;
  assign is_seg = (AVS_ADDRESS & REG_SEG_MASK) == REG_SEG_BASE;
  assign bus_inv = bw && at(AVS_ADDRESS, REG_INVAL);
  assign inv_idx = AVS_WRITEDATA[17:12];

  // Read mux; unmapped words read zero
  assign next_rdata = at(AVS_ADDRESS, REG_CTRL) ? {31'h0000_0000, en_r} :
    at(AVS_ADDRESS, REG_STAT) ? {28'h000_0000, st[1] == ST_WALK,
    st[0] == ST_WALK, ill_pend, SYNC_STALL} :
    is_seg ? seg[0][AVS_ADDRESS[5:2]] : 32'h0000_0000;

  // Waitrequest drops for one cycle per request
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end
    else
    begin
      AVS_WAITREQUEST <= !bus_go;
      if (bus_go)
        AVS_READDATA <= next_rdata;
    end
  end

  // ----------------------------------------
  // Control, sync and illegal opcode
  // ----------------------------------------
  logic next_sync;
  logic next_ill;
  logic repi;
  logic [1:0] rep;
  assign next_sync = (bw && at(AVS_ADDRESS, REG_SYNC)) || (SYNC_STALL && hs2);
  assign next_ill = (bw && at(AVS_ADDRESS, REG_INVALL)) || (ill_pend && !repi);

  // Translation is off after reset; valid bits are never reset
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      en_r <= CTRL_EN_RST;
      SYNC_STALL <= 1'b0;
      ill_pend <= 1'b0;
      hs1 <= 1'b0;
      hs2 <= 1'b0;
    end
    else
    begin
      if (bw && at(AVS_ADDRESS, REG_CTRL))
        en_r <= AVS_WRITEDATA[CTRL_EN];
      SYNC_STALL <= next_sync;
      ill_pend <= next_ill;
      hs1 <= SYNC_HOLD;
      hs2 <= hs1;
    end
  end

  // ----------------------------------------
  // Lookup per translation unit
  // ----------------------------------------
  tlb_req_s rq [TLB_UNITS];
  tlb_ent_s e0 [TLB_UNITS];
  tlb_ent_s e1 [TLB_UNITS];
  tlb_ent_s he [TLB_UNITS];
  logic [5:0] idx [TLB_UNITS];
  logic [39:0] vpn_n [TLB_UNITS];
  logic [1:0] m0;
  logic [1:0] m1;
  logic [1:0] hit;
  logic [1:0] viol;
  logic [1:0] aln;
  logic [1:0] chg;
  logic [1:0] act;
  logic [1:0] pass;
  logic [1:0] fp;
  logic [1:0] gw;
  logic [1:0] good;
  logic [1:0] fin;
  logic [1:0] lost;
  logic [1:0] need;
  logic [1:0] vict;
  logic [1:0] key;

  assign rq[0] = I_REQ;
  assign rq[1] = D_REQ;
  assign I_RSP = rsp[0];
  assign D_RSP = rsp[1];

  // One identical lookup path per buffer
  for (genvar u = 0; u < TLB_UNITS; u++)
  begin : g_unit
    logic [31:0] sr;
    assign sr = seg[u][rq[u].ea[31:28]];
    assign idx[u] = rq[u].ea[17:12];
    assign e0[u] = ent[u][idx[u]][0];
    assign e1[u] = ent[u][idx[u]][1];
    assign vpn_n[u] = {sr[23:0], rq[u].ea[27:12]};
    assign m0[u] = e0[u].v
      && {e0[u].segment_identifier, e0[u].abbreviated_page_index, e0[u].extended_page_index, idx[u]} == vpn_n[u];
    assign m1[u] = e1[u].v
      && {e1[u].segment_identifier, e1[u].abbreviated_page_index, e1[u].extended_page_index, idx[u]} == vpn_n[u];
    assign hit[u] = m0[u] || m1[u];
    assign he[u] = m1[u] ? e1[u] : e0[u];
    assign key[u] = rq[u].sup ? sr[SEG_KS] : sr[SEG_KP];
    // Page protection by key and protection_bits
    assign viol[u] = key[u] ? (he[u].pp == 2'h0 || (rq[u].wr && he[u].pp != 2'h2))
      : (rq[u].wr && he[u].pp == 2'h3);
    assign aln[u] = rq[u].zero && (he[u].storage_attributes[ATTR_W] || he[u].storage_attributes[ATTR_I]);
    assign chg[u] = rq[u].wr && !he[u].c;
    assign act[u] = rq[u].req && !rsp[u].done && st[u] == ST_LOOK && fc[u] == EXC_NONE;
    assign pass[u] = act[u] && !en_r;
    assign fp[u] = act[u] && en_r && hit[u] && (viol[u] || aln[u]);
    assign gw[u] = act[u] && en_r && !rq[u].ooo
      && (!hit[u] || (!viol[u] && !aln[u] && chg[u]));
    assign good[u] = act[u] && en_r && hit[u] && !viol[u] && !aln[u] && !chg[u];
    assign fin[u] = st[u] == ST_WALK && WALK_RET.done && WALK_REQ.req
      && WALK_REQ.side == 1'(u);
    assign lost[u] = fin[u] && !WALK_RET.found;
    assign need[u] = st[u] == ST_WALK && !(WALK_REQ.req && WALK_REQ.side == 1'(u));
    assign vict[u] = !e0[u].v ? 1'b0 : !e1[u].v ? 1'b1 : lru[u][idx[u]];
  end

  // ----------------------------------------
  // Unit state and responses
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      for (int u = 0; u < TLB_UNITS; u++)
      begin
        st[u] <= ST_LOOK;
        fc[u] <= EXC_NONE;
        rsp[u] <= '0;
        vpn_r[u] <= 40'h00_0000_0000;
      end
      chg_r <= 2'b00;
      way_r <= 2'b00;
    end
    else
    begin
      for (int u = 0; u < TLB_UNITS; u++)
      begin
        rsp[u].done <= pass[u] || fp[u] || good[u] || lost[u];
        rsp[u].hit <= pass[u] || good[u];
        rsp[u].real_frame_number <= pass[u] ? rq[u].ea[31:12] : he[u].real_frame_number;
        rsp[u].attr <= pass[u] ? 4'h0 : he[u].storage_attributes;
        if (rep[u])
          fc[u] <= EXC_NONE;
        else if (fp[u])
          fc[u] <= viol[u] ? EXC_PROT : EXC_ALIGN;
        else if (lost[u])
          fc[u] <= EXC_MISS;
        if (gw[u])
        begin
          st[u] <= ST_WALK;
          vpn_r[u] <= vpn_n[u];
          chg_r[u] <= hit[u];
          way_r[u] <= hit[u] ? m1[u] : vict[u];
        end
        else if (fin[u])
          st[u] <= ST_LOOK;
      end
    end
  end

  // ----------------------------------------
  // Arrays: refill, LRU, segments, invalidate
  // ----------------------------------------
  // No reset here: valid bits survive reset
  always_ff @(posedge REF_CLK)
  begin
    for (int u = 0; u < TLB_UNITS; u++)
    begin
      if (act[u] && en_r && hit[u])
        lru[u][idx[u]] <= !m1[u];
      if (fin[u] && WALK_RET.found)
        ent[u][vpn_r[u][5:0]][way_r[u]] <= {1'b1, vpn_r[u][39:16],
          vpn_r[u][9:6], vpn_r[u][15:10], WALK_RET.real_frame_number, WALK_RET.storage_attributes,
          WALK_RET.pp, WALK_RET.c};
      if (bw && is_seg)
        seg[u][AVS_ADDRESS[5:2]] <= AVS_WRITEDATA;
      // Local only: nothing sent out, nothing taken in; prefetch untouched
      if (bus_inv)
      begin
        ent[u][inv_idx][0].v <= 1'b0;
        ent[u][inv_idx][1].v <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Walker port, data side first
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
      WALK_REQ <= '0;
    else if (WALK_REQ.req)
    begin
      if (WALK_RET.done)
        WALK_REQ.req <= 1'b0;
    end
    else if (|need)
    begin
      WALK_REQ.req <= 1'b1;
      WALK_REQ.side <= need[1];
      WALK_REQ.chg <= need[1] ? chg_r[1] : chg_r[0];
      WALK_REQ.virtual_page_number <= need[1] ? vpn_r[1] : vpn_r[0];
    end
  end

  // ----------------------------------------
  // Exception reporting
  // ----------------------------------------
  // Data side wins; miss faults wait for rdy
  assign rep[1] = fc[1] != EXC_NONE && D_REQ.rdy;
  assign rep[0] = fc[0] != EXC_NONE && I_REQ.rdy && !rep[1];
  assign repi = ill_pend && rep == 2'b00;

  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      EXC_VALID <= 1'b0;
      EXC_SIDE <= 1'b0;
      EXC_CODE <= EXC_NONE;
    end
    else
    begin
      EXC_VALID <= rep != 2'b00 || repi;
      EXC_SIDE <= rep[1];
      EXC_CODE <= rep[1] ? fc[1] : rep[0] ? fc[0] : repi ? EXC_ILLEGAL : EXC_NONE;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);

  chk_seg_both_copies: assert property (
    bw && is_seg |=> seg[0][$past(AVS_ADDRESS[5:2])] == seg[1][$past(AVS_ADDRESS[5:2])])
    else $error("segment copies differ");

  chk_inval_four: assert property (
    bus_inv |=> !ent[0][$past(inv_idx)][0].v && !ent[0][$past(inv_idx)][1].v
      && !ent[1][$past(inv_idx)][0].v && !ent[1][$past(inv_idx)][1].v)
    else $error("invalidate left an entry valid");

  chk_sync_hold: assert property (
    SYNC_STALL && hs2 |=> SYNC_STALL) else $error("sync stall dropped early");

  chk_invall_illegal: assert property (
    bw && at(AVS_ADDRESS, REG_INVALL) |=> ill_pend) else $error("invalidate-all not trapped");

  for (genvar u = 0; u < TLB_UNITS; u++)
  begin : g_chk
    chk_ooo_defer: assert property (
      act[u] && en_r && !hit[u] && rq[u].ooo |=> st[u] == ST_LOOK)
      else $error("out-of-order miss started a walk");
    chk_prot_first: assert property (
      act[u] && en_r && hit[u] && viol[u] |=> rsp[u].done && !rsp[u].hit
        && fc[u] == EXC_PROT) else $error("protection fault missed");
    chk_chg_walk: assert property (
      gw[u] && hit[u] |=> st[u] == ST_WALK && !rsp[u].done ##1 !rsp[u].done)
      else $error("changed-bit update not walked");
    chk_hit_frame: assert property (
      good[u] |=> rsp[u].done && rsp[u].hit && rsp[u].real_frame_number == $past(he[u].real_frame_number)
        && rsp[u].attr == $past(he[u].storage_attributes)) else $error("hit answer wrong");
    chk_lru_use: assert property (
      act[u] && en_r && hit[u] |=> lru[u][$past(idx[u])] == !$past(m1[u]))
      else $error("lru not updated");
    chk_miss_rdy: assert property (
      fc[u] == EXC_MISS && !rq[u].rdy |=> fc[u] == EXC_MISS)
      else $error("miss fault reported before ready");
  end

endmodule // tlb_top

// *** bench/tlb_walk_model.sv ***
// Page-table walker stand-in answering refill and changed-bit searches
`timescale 1ns/10ps
module tlb_walk_model (
  input wire logic clk,
  input wire logic rst_n,
  input tlb_pkg::tlb_walk_s walk_req,
  input wire logic found,
  input wire logic [3:0] storage_attributes,
  input wire logic [1:0] pp,
  input wire logic c,
  input wire logic [2:0] lat,
  output tlb_pkg::tlb_wret_s walk_ret
);
  import tlb_pkg::*;
  logic busy;
  logic gap;
  logic [2:0] cnt;
  // ------------
  // Search answer
  // ------------
  // One answer per request lat+1 cycles after it is taken; idle fields toggle so stale data never looks valid
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      gap <= 1'b0;
      cnt <= 3'h0;
      walk_ret <= '0;
    end
    else
    begin
      if (busy && cnt == 3'h0)
      begin
        busy <= 1'b0;
        gap <= 1'b1;
        walk_ret <= '{1'b1, found, walk_req.virtual_page_number[19:0] ^ 20'h5_A5A5, storage_attributes, pp, c};
      end
      else
      begin
        // Between answers show the inverse of the last one, never a done
        walk_ret <= '{1'b0, ~walk_ret.found, ~walk_ret.real_frame_number, ~walk_ret.storage_attributes,
          ~walk_ret.pp, ~walk_ret.c};
        if (!walk_req.req)
          gap <= 1'b0;
        if (busy)
          cnt <= cnt - 3'h1;
        else if (walk_req.req && !gap)
        begin
          busy <= 1'b1;
          cnt <= lat;
        end
      end
    end
  end
endmodule // tlb_walk_model

// *** bench/tlb_translation_lookup_tb_top.sv ***
// Self-checking bench for the translation lookaside block
`timescale 1ns/10ps
module tlb_translation_lookup_tb_top;
  import tlb_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  tlb_req_s i_req;
  tlb_req_s d_req;
  tlb_rsp_s i_rsp;
  tlb_rsp_s d_rsp;
  tlb_walk_s walk_req;
  tlb_wret_s walk_ret;
  logic sync_hold;
  logic sync_stall;
  logic exc_valid;
  logic exc_side;
  tlb_exc_e exc_code;
  logic w_found;
  logic [3:0] w_storage_attributes;
  logic [1:0] w_pp;
  logic w_c;
  logic [2:0] w_lat;
  tlb_rsp_s rsp;
  logic walked;
  logic chg;
  logic [39:0] virtual_page_number;
  logic [31:0] rd;
  tlb_exc_e exc_c;
  logic exc_s;
  int exc_n = 0;
  int k;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;

  tlb_top uut (.REF_CLK(ref_clk), .NRST(nrst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .I_REQ(i_req), .D_REQ(d_req), .I_RSP(i_rsp),
    .D_RSP(d_rsp), .WALK_REQ(walk_req), .WALK_RET(walk_ret), .SYNC_HOLD(sync_hold),
    .SYNC_STALL(sync_stall), .EXC_VALID(exc_valid), .EXC_SIDE(exc_side), .EXC_CODE(exc_code));
  tlb_walk_model walker (.clk(ref_clk), .rst_n(nrst), .walk_req(walk_req), .found(w_found),
    .storage_attributes(w_storage_attributes), .pp(w_pp), .c(w_c), .lat(w_lat), .walk_ret(walk_ret));

  // ------------
  // Clock, exception log, watchdog
  // ------------
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (exc_valid === 1'b1)
    begin
      exc_n <= exc_n + 1;
      exc_c <= exc_code;
      exc_s <= exc_side;
    end
    if (cycles == 20000)
    begin
      failures++;
      tally_and_finish;
    end
  end

  // ------------
  // Helpers
  // ------------
  function automatic logic [31:0] segw(input int n);
    return {2'b00, n == 3, 5'h00, 20'hA_BCD0, 4'(n)};
  endfunction
  function automatic logic [39:0] ev(input logic [31:0] ea);
    return {20'hA_BCD0, ea[31:12]};
  endfunction
  task automatic chk_val(input string s, input logic [39:0] e, input logic [39:0] g);
    begin
      check_count++;
      if (g !== e)
      begin
        failures++;
        $display("ERROR %s expected %h seen %h", s, e, g);
      end
    end
  endtask
  task automatic chk_bit(input string s, input logic e, input logic g);
    chk_val(s, 40'(e), 40'(g));
  endtask
  task automatic chk_exc(input string s, input tlb_exc_e e, input int n);
    chk_val(s, {36'h0_0000_0001, e, 1'b1}, {36'(n - k), exc_c, exc_s});
  endtask
  // Avalon access held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    begin
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= w;
      avs_read <= ~w;
      do
        @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  // Lookup held until done; notes any walk seen meanwhile
  task automatic look(input logic d, input logic [31:0] ea, input logic wr, input logic zr,
    input logic rdy);
    tlb_req_s q;
    begin
      q = '{1'b1, ea, wr, 1'b0, rdy, zr, 1'b0};
      walked = 1'b0;
      if (d) d_req <= q;
      else i_req <= q;
      do
      begin
        @(posedge ref_clk);
        rsp = d ? d_rsp : i_rsp;
        if (walk_req.req === 1'b1)
        begin
          walked = 1'b1;
          virtual_page_number = walk_req.virtual_page_number;
          chg = walk_req.chg;
        end
      end while (rsp.done !== 1'b1);
      q.req = 1'b0;
      if (d) d_req <= q;
      else i_req <= q;
      @(posedge ref_clk);
    end
  endtask

  // ------------
  // Scenarios
  // ------------
  task automatic t_reset;
    begin
      bus(1'b0, REG_CTRL, 32'h0000_0000);
      chk_bit("ctrl_en", CTRL_EN_RST, rd[CTRL_EN]);
      bus(1'b0, 8'h24, 32'h0000_0000);
      chk_val("unmapped", 40'h00_0000_0000, 40'(rd));
      look(1'b0, 32'h1234_5678, 1'b0, 1'b0, 1'b1);
      chk_val("pass_rpn", 40'h00_0001_2345, 40'(rsp.real_frame_number));
      chk_bit("pass_walk", 1'b0, walked);
    end
  endtask
  task automatic t_setup;
    begin
      for (int i = 0; i < 64; i++) bus(1'b1, REG_INVAL, 32'(i) << 12);
      for (int i = 0; i < 16; i++) bus(1'b1, 8'(REG_SEG_BASE + 4 * i), segw(i));
      bus(1'b0, 8'h54, 32'h0000_0000);
      chk_val("seg5", 40'(segw(5)), 40'(rd));
      bus(1'b1, REG_CTRL, 32'h0000_0001);
    end
  endtask
  task automatic t_refill;
    begin
      look(1'b1, 32'h1000_3000, 1'b0, 1'b0, 1'b1);
      chk_bit("miss_walk", 1'b1, walked);
      chk_val("walk_vpn", ev(32'h1000_3000), virtual_page_number);
      chk_bit("refill_hit", 1'b1, rsp.hit);
      chk_val("rpn", 40'(20'h1_0003 ^ 20'h5_A5A5), 40'(rsp.real_frame_number));
      chk_val("attr", 40'h00_0000_0002, 40'(rsp.attr));
      look(1'b1, 32'h1000_3000, 1'b0, 1'b0, 1'b1);
      chk_bit("hit_nowalk", 1'b0, walked);
      look(1'b0, 32'h1000_3000, 1'b0, 1'b0, 1'b1);
      chk_bit("i_own_walk", 1'b1, walked);
    end
  endtask
  task automatic t_lru;
    begin
      look(1'b1, 32'h1004_3000, 1'b0, 1'b0, 1'b1);
      chk_bit("epi_miss", 1'b1, walked);
      look(1'b1, 32'h1000_3000, 1'b0, 1'b0, 1'b1);
      chk_bit("way_kept", 1'b0, walked);
      w_lat <= 3'h5;
      look(1'b1, 32'h1100_3000, 1'b0, 1'b0, 1'b1);
      look(1'b1, 32'h1000_3000, 1'b0, 1'b0, 1'b1);
      chk_bit("lru_keep", 1'b0, walked);
      look(1'b1, 32'h1004_3000, 1'b0, 1'b0, 1'b1);
      chk_bit("lru_evict", 1'b1, walked);
      w_lat <= 3'h0;
    end
  endtask
  task automatic t_ooo;
    begin
      k = 0;
      d_req <= '{1'b1, 32'h2000_5000, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
      repeat (20)
      begin
        @(posedge ref_clk);
        if (walk_req.req === 1'b1) k++;
      end
      chk_val("ooo_hold", 40'h00_0000_0000, 40'(k));
      look(1'b1, 32'h2000_5000, 1'b0, 1'b0, 1'b1);
      chk_bit("ooo_later", 1'b1, walked);
    end
  endtask
  task automatic t_change;
    begin
      w_c <= 1'b0;
      look(1'b1, 32'h4000_9000, 1'b0, 1'b0, 1'b1);
      w_c <= 1'b1;
      look(1'b1, 32'h4000_9000, 1'b1, 1'b0, 1'b1);
      chk_bit("chg_walk", 1'b1, walked & chg);
      look(1'b1, 32'h4000_9000, 1'b1, 1'b0, 1'b1);
      chk_bit("chg_done", 1'b0, walked);
    end
  endtask
  task automatic t_fault;
    begin
      k = exc_n;
      w_pp <= 2'h0;
      look(1'b1, 32'h3000_7000, 1'b0, 1'b0, 1'b1);
      repeat (3) @(posedge ref_clk);
      chk_bit("prot_hit", 1'b0, rsp.hit);
      chk_exc("prot_exc", EXC_PROT, exc_n);
      k = exc_n;
      w_pp <= 2'h2;
      w_storage_attributes <= 4'h8;
      look(1'b1, 32'h5000_B000, 1'b1, 1'b1, 1'b1);
      repeat (3) @(posedge ref_clk);
      chk_exc("align_exc", EXC_ALIGN, exc_n);
      k = exc_n;
      w_storage_attributes <= 4'h2;
      w_found <= 1'b0;
      look(1'b1, 32'h6000_D000, 1'b0, 1'b0, 1'b0);
      repeat (8) @(posedge ref_clk);
      chk_val("miss_wait", 40'(k), 40'(exc_n));
      d_req.rdy <= 1'b1;
      w_found <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk_exc("miss_exc", EXC_MISS, exc_n);
    end
  endtask
  task automatic t_inval;
    begin
      bus(1'b1, REG_INVAL, 32'h0000_3000);
      look(1'b1, 32'h1000_3000, 1'b0, 1'b0, 1'b1);
      chk_bit("d_inval", 1'b1, walked);
      look(1'b0, 32'h1000_3000, 1'b0, 1'b0, 1'b1);
      chk_bit("i_inval", 1'b1, walked);
    end
  endtask
  task automatic t_sync_ill;
    begin
      sync_hold <= 1'b1;
      bus(1'b1, REG_SYNC, 32'h0000_0000);
      repeat (5) @(posedge ref_clk);
      chk_bit("stall_on", 1'b1, sync_stall);
      sync_hold <= 1'b0;
      repeat (5) @(posedge ref_clk);
      chk_bit("stall_off", 1'b0, sync_stall);
      k = exc_n;
      bus(1'b1, REG_INVALL, 32'h0000_0000);
      repeat (4) @(posedge ref_clk);
      chk_val("ill_code", 40'(EXC_ILLEGAL), 40'(exc_c));
    end
  endtask
  task automatic tally_and_finish;
    begin
      $display("TB: checks %0d errors %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // ------------
  // Main sequence
  // ------------
  initial
  begin
    nrst = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    i_req = '0;
    d_req = '0;
    sync_hold = 1'b0;
    w_found = 1'b1;
    w_storage_attributes = 4'h2;
    w_pp = 2'h2;
    w_c = 1'b1;
    w_lat = 3'h0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_setup;
    t_refill;
    t_lru;
    t_ooo;
    t_change;
    t_fault;
    t_inval;
    t_sync_ill;
    tally_and_finish;
  end
endmodule // tlb_translation_lookup_tb_top
